// *** shared/fmep_cfg.svh ***
/*
 * Offsets, field positions, reset values and timing figures of the flash mass-erase block.
 * Assumes a 32-bit word-aligned register bus and a 125 MHz system clock.
 */
`ifndef FMEP_CFG_SVH
`define FMEP_CFG_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define FMEP_OFS_ADDR 8'h00
`define FMEP_OFS_CTRL 8'h08
`define FMEP_OFS_RIS 8'h0C
`define FMEP_OFS_MASK 8'h10
`define FMEP_OFS_RECOV 8'h14
`define FMEP_OFS_PPW0 8'h20
`define FMEP_OFS_RPW0 8'h30

// ****************************************************************
// fields
// ****************************************************************
`define FMEP_CTRL_KEY 16'hA442
`define FMEP_CTRL_MASS_BIT 2
`define FMEP_CTRL_PAGE_BIT 1
`define FMEP_ADDR_HALF_BIT 17
`define FMEP_ADDR_W 18
`define FMEP_RIS_ACCERR_BIT 0
`define FMEP_RIS_DONE_BIT 1
`define FMEP_RECOV_GO_BIT 0

// ****************************************************************
// reset values
// ****************************************************************
`define FMEP_RST_ZERO 32'h0000_0000
`define FMEP_RST_ONES 32'hFFFF_FFFF

// ****************************************************************
// timing
// ****************************************************************
`define FMEP_CLK_PERIOD_NS 8
`define FMEP_MASS_ERASE_TIME_NS 16000
`define FMEP_PAGE_ERASE_TIME_NS 4000

`endif

// *** shared/fmep_pkg.sv ***
/*
 * Types shared by the flash mass-erase block, its checker and its bench.
 * Assumes fmep_cfg.svh is on the include path.
 */
`include "fmep_cfg.svh"

package fmep_pkg;

   // ****************************************************************
   // bus and flash-array carriers
   // ****************************************************************
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [7:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } fmep_wb_req_t;

   typedef struct packed {
      logic erase_lo;
      logic erase_hi;
      logic erase_page;
      logic [`FMEP_ADDR_W-1:0] page_addr;
   } fmep_erase_t;

   typedef enum logic [1:0] {
      FMEP_IDLE,
      FMEP_MASS,
      FMEP_PAGE
   } fmep_state_t;

   // one bit per 2 KB block: set where the block is implemented
   function automatic logic [127:0] fmep_impl_mask(input int flash_kb);
      logic [127:0] m;
      m = '0;
      for (int i = 0; i < 128; i++) begin
         m[i] = (i < flash_kb / 2);
      end
      return m;
   endfunction : fmep_impl_mask

endpackage : fmep_pkg

// *** hw/fmep_erase_timer.sv ***
/*
 * Erase duration timer: counts a requested number of cycles after a start pulse.
 * Assumes start is only pulsed while not busy.
 */
`timescale 1ns/1ps

module fmep_erase_timer #(
   parameter int CNT_W = 16
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_start,
   input wire logic [CNT_W-1:0] i_cycles,
   output logic o_busy,
   output logic o_done
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   logic busy_q;
   logic busy_d;
   logic done_q;
   wire last = busy_q && (cnt_q == {{(CNT_W-1){1'b0}}, 1'b1});

   assign cnt_d = i_start ? i_cycles : (busy_q ? cnt_q - {{(CNT_W-1){1'b0}}, 1'b1} : cnt_q);
   assign busy_d = i_start ? 1'b1 : (last ? 1'b0 : busy_q);

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         busy_q <= busy_d;
         done_q <= last;
      end
   end

   assign o_busy = busy_q;
   assign o_done = done_q;

endmodule : fmep_erase_timer

// *** hw/fmep_top.sv ***
/*
 * Flash controller erase sequencer with program-protection check, Wishbone classic slave.
 * Assumes a flash array outside that erases the region while the erase enables are high.
 */
// Operation
// - mass erase with address below 0x20000 erases only the lower 128 KB
// - protection words of the selected half are checked before mass erase; protected flash in that half suppresses it
// - rejected mass erase sets the access error raw flag
// - locked-device recovery restores protection words 2 and 3 to all ones
`timescale 1ns/1ps

module fmep_top
   import fmep_pkg::*;
#(
   parameter int FLASH_KB = 128,
   parameter int MASS_ERASE_TIME_NS = `FMEP_MASS_ERASE_TIME_NS,
   parameter int PAGE_ERASE_TIME_NS = `FMEP_PAGE_ERASE_TIME_NS
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire fmep_pkg::fmep_wb_req_t i_wb,
   output logic o_wb_ack,
   output logic [31:0] o_wb_dat,
   output logic o_irq,
   output fmep_pkg::fmep_erase_t o_erase
);

   // ****************************************************************
   // constants and elaboration checks
   // ****************************************************************
   localparam int CNT_W = 16;
   localparam int MASS_CYC_I = (MASS_ERASE_TIME_NS + `FMEP_CLK_PERIOD_NS - 1) / `FMEP_CLK_PERIOD_NS;
   localparam int PAGE_CYC_I = (PAGE_ERASE_TIME_NS + `FMEP_CLK_PERIOD_NS - 1) / `FMEP_CLK_PERIOD_NS;
   localparam logic [CNT_W-1:0] MASS_CYC = CNT_W'((MASS_CYC_I < 1) ? 1 : MASS_CYC_I);
   localparam logic [CNT_W-1:0] PAGE_CYC = CNT_W'((PAGE_CYC_I < 1) ? 1 : PAGE_CYC_I);
   localparam logic [127:0] IMPL = fmep_impl_mask(FLASH_KB);

   generate
      if (FLASH_KB < 32 || FLASH_KB > 256 || (FLASH_KB % 32) != 0) begin : g_bad_size
         $error("FLASH_KB must be a multiple of 32 from 32 to 256");
      end
      if (MASS_CYC_I >= 65536 || PAGE_CYC_I >= 65536) begin : g_bad_time
         $error("erase time exceeds timer width");
      end
   endgenerate

   // ****************************************************************
   // state
   // ****************************************************************
   logic [`FMEP_ADDR_W-1:0] addr_q;
   logic [`FMEP_ADDR_W-1:0] addr_d;
   logic [31:0] ppw_q [4];
   logic [31:0] rpw_q [4];
   logic [1:0] ris_q;
   logic [1:0] ris_d;
   logic [1:0] mask_q;
   logic [1:0] mask_d;
   fmep_state_t st_q;
   fmep_state_t st_d;
   logic ack_q;
   logic [31:0] dat_q;
   logic irq_q;
   fmep_erase_t erase_q;
   fmep_erase_t erase_d;
   logic tmr_done;
   logic [31:0] addr_merged;

   // ****************************************************************
   // bus decode
   // ****************************************************************
   wire bus_go = i_wb.cyc && i_wb.stb && !ack_q;
   wire wr_go = bus_go && i_wb.we;
   wire hit_addr = i_wb.adr == `FMEP_OFS_ADDR;
   wire hit_ctrl = i_wb.adr == `FMEP_OFS_CTRL;
   wire hit_ris = i_wb.adr == `FMEP_OFS_RIS;
   wire hit_mask = i_wb.adr == `FMEP_OFS_MASK;
   wire hit_recov = i_wb.adr == `FMEP_OFS_RECOV;
   wire hit_ppw = i_wb.adr[7:4] == `FMEP_OFS_PPW0 >> 4;
   wire hit_rpw = i_wb.adr[7:4] == `FMEP_OFS_RPW0 >> 4;
   wire [1:0] word_idx = i_wb.adr[3:2];
   wire [31:0] be_mask = {{8{i_wb.sel[3]}}, {8{i_wb.sel[2]}}, {8{i_wb.sel[1]}}, {8{i_wb.sel[0]}}};

   function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [31:0] m);
      be_merge = (old & ~m) | (nw & m);
   endfunction : be_merge

   // ****************************************************************
   // command decode and protection check
   // ****************************************************************
   // only a full-word write with the key can start an erase
   wire key_ok = (i_wb.sel == 4'hF) && (i_wb.dat[31:16] == `FMEP_CTRL_KEY);
   wire ctrl_wr = wr_go && hit_ctrl && key_ok && (st_q == FMEP_IDLE);
   wire mass_cmd = ctrl_wr && i_wb.dat[`FMEP_CTRL_MASS_BIT];
   wire page_cmd = ctrl_wr && !i_wb.dat[`FMEP_CTRL_MASS_BIT] && i_wb.dat[`FMEP_CTRL_PAGE_BIT];
   wire upper_sel = addr_q[`FMEP_ADDR_HALF_BIT];
   wire [127:0] ppw_all = {ppw_q[3], ppw_q[2], ppw_q[1], ppw_q[0]};
   wire [63:0] half_ppw = upper_sel ? ppw_all[127:64] : ppw_all[63:0];
   wire [63:0] half_impl = upper_sel ? IMPL[127:64] : IMPL[63:0];
   // any protected implemented block in the selected half, or any enable set there for absent flash, inhibits the erase
   wire mass_reject = half_ppw != half_impl;
   wire [6:0] blk_idx = addr_q[17:11];
   wire page_reject = !ppw_all[blk_idx];
   wire mass_ok = mass_cmd && !mass_reject;
   wire page_ok = page_cmd && !page_reject;
   wire acc_err_ev = (mass_cmd && mass_reject) || (page_cmd && page_reject);
   wire tmr_start = mass_ok || page_ok;
   wire [CNT_W-1:0] tmr_cycles = mass_ok ? MASS_CYC : PAGE_CYC;
   wire recov_go = wr_go && hit_recov && i_wb.sel[0] && i_wb.dat[`FMEP_RECOV_GO_BIT];

   // ****************************************************************
   // erase sequencer
   // ****************************************************************
   always_comb begin
      st_d = st_q;
      erase_d = erase_q;
      case (st_q)
         FMEP_IDLE: begin
            if (mass_ok) begin
               st_d = FMEP_MASS;
               erase_d.erase_lo = !upper_sel;
               erase_d.erase_hi = upper_sel;
               erase_d.erase_page = 1'b0;
               erase_d.page_addr = addr_q;
            end else if (page_ok) begin
               st_d = FMEP_PAGE;
               erase_d.erase_lo = 1'b0;
               erase_d.erase_hi = 1'b0;
               erase_d.erase_page = 1'b1;
               erase_d.page_addr = {addr_q[`FMEP_ADDR_W-1:10], 10'h000};
            end
         end
         FMEP_MASS, FMEP_PAGE: begin
            if (tmr_done) begin
               st_d = FMEP_IDLE;
               erase_d.erase_lo = 1'b0;
               erase_d.erase_hi = 1'b0;
               erase_d.erase_page = 1'b0;
            end
         end
         default: begin
            st_d = FMEP_IDLE;
            erase_d = '0;
         end
      endcase
   end

   fmep_erase_timer #(
      .CNT_W(CNT_W)
   ) u_timer (
      .i_clk_sys(i_clk_sys),
      .i_rst_b(i_rst_b),
      .i_start(tmr_start),
      .i_cycles(tmr_cycles),
      .o_busy(),
      .o_done(tmr_done)
   );

   // ****************************************************************
   // interrupt status and mask
   // ****************************************************************
   wire [1:0] ev = {tmr_done, acc_err_ev};
   wire [1:0] w1c = (wr_go && hit_ris && i_wb.sel[0]) ? i_wb.dat[1:0] : 2'b00;
   // a new event wins over a clear in the same cycle
   assign ris_d = (ris_q & ~w1c) | ev;
   assign mask_d = (wr_go && hit_mask && i_wb.sel[0]) ? i_wb.dat[1:0] : mask_q;
   assign addr_merged = be_merge(32'(addr_q), i_wb.dat, be_mask);
   assign addr_d = (wr_go && hit_addr) ? addr_merged[`FMEP_ADDR_W-1:0] : addr_q;

   // ****************************************************************
   // read mux
   // ****************************************************************
   wire busy_mass = st_q == FMEP_MASS;
   wire busy_page = st_q == FMEP_PAGE;
   wire [31:0] ctrl_rd = {29'h0, busy_mass, busy_page, 1'b0};
   wire [31:0] rd_mux = hit_addr ? 32'(addr_q) :
                        hit_ctrl ? ctrl_rd :
                        hit_ris ? {30'h0, ris_q} :
                        hit_mask ? {30'h0, mask_q} :
                        hit_ppw ? ppw_q[word_idx] :
                        hit_rpw ? rpw_q[word_idx] :
                        32'h0000_0000;

   // ****************************************************************
   // protection word banks
   // ****************************************************************
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_prot
         localparam logic [31:0] PPW_RST = IMPL[gi*32 +: 32];
         wire ppw_wr = wr_go && hit_ppw && (word_idx == 2'(gi));
         wire rpw_wr = wr_go && hit_rpw && (word_idx == 2'(gi));
         // recovery puts all ones back into the upper words
         wire recov_hit = recov_go && (gi >= 2);
         wire [31:0] ppw_d = recov_hit ? `FMEP_RST_ONES :
                             ppw_wr ? be_merge(ppw_q[gi], i_wb.dat, be_mask) : ppw_q[gi];
         wire [31:0] rpw_d = rpw_wr ? be_merge(rpw_q[gi], i_wb.dat, be_mask) : rpw_q[gi];
         always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
            if (!i_rst_b) begin
               ppw_q[gi] <= PPW_RST;
               rpw_q[gi] <= `FMEP_RST_ONES;
            end else begin
               ppw_q[gi] <= ppw_d;
               rpw_q[gi] <= rpw_d;
            end
         end
      end
   endgenerate

   // ****************************************************************
   // registers
   // ****************************************************************
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         addr_q <= '0;
         ris_q <= 2'h0;
         mask_q <= 2'h0;
         st_q <= FMEP_IDLE;
         erase_q <= '0;
      end else begin
         addr_q <= addr_d;
         ris_q <= ris_d;
         mask_q <= mask_d;
         st_q <= st_d;
         erase_q <= erase_d;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ack_q <= 1'b0;
         dat_q <= 32'h0000_0000;
         irq_q <= 1'b0;
      end else begin
         ack_q <= bus_go;
         dat_q <= bus_go ? rd_mux : 32'h0000_0000;
         irq_q <= |(ris_d & mask_d);
      end
   end

   // ****************************************************************
   // outputs
   // ****************************************************************
   assign o_wb_ack = ack_q;
   assign o_wb_dat = dat_q;
   assign o_irq = irq_q;
   assign o_erase = erase_q;

endmodule : fmep_top

// *** tb/fmep_top_asserts.sv ***
/*
 * Port-level checker for the flash mass-erase block.
 * Assumes binding into fmep_top with its timing parameters handed on.
 */
`timescale 1ns/1ps
`include "fmep_cfg.svh"
module fmep_top_asserts
   import fmep_pkg::*;
#(
   parameter int FLASH_KB = 128,
   parameter int MASS_ERASE_TIME_NS = `FMEP_MASS_ERASE_TIME_NS,
   parameter int PAGE_ERASE_TIME_NS = `FMEP_PAGE_ERASE_TIME_NS
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire fmep_pkg::fmep_wb_req_t i_wb,
   input wire logic o_wb_ack,
   input wire logic [31:0] o_wb_dat,
   input wire logic o_irq,
   input wire fmep_pkg::fmep_erase_t o_erase
);
   localparam int MC = MASS_ERASE_TIME_NS / `FMEP_CLK_PERIOD_NS;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   // ****
   // helpers
   // ****
   wire logic mass_on = o_erase.erase_lo | o_erase.erase_hi;
   wire logic take = i_wb.cyc & i_wb.stb & !o_wb_ack;
   wire logic bad_key = take & i_wb.we & (i_wb.adr == `FMEP_OFS_CTRL) & (i_wb.dat[31:16] != `FMEP_CTRL_KEY)
      & !mass_on & !o_erase.erase_page;
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   assign cnt_d = mass_on ? cnt_q + 16'h1 : 16'h0;
   always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) cnt_q <= 16'h0;
      else cnt_q <= cnt_d;
   end
   // ****
   // properties
   // ****
   property p_ack_resp; take |=> o_wb_ack; endproperty
   a_ack_resp: assert property (p_ack_resp) else $error("no ack one cycle after a request");
   property p_ack_pulse; o_wb_ack |=> !o_wb_ack; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
   property p_dat_zero; !o_wb_ack |-> o_wb_dat == 32'h0; endproperty
   a_dat_zero: assert property (p_dat_zero) else $error("read data nonzero without ack");
   property p_lo_addr; o_erase.erase_lo |-> !o_erase.page_addr[17]; endproperty
   a_lo_addr: assert property (p_lo_addr) else $error("lower erase with high address");
   property p_hi_addr; o_erase.erase_hi |-> o_erase.page_addr[17]; endproperty
   a_hi_addr: assert property (p_hi_addr) else $error("upper erase with low address");
   property p_one_half; !(o_erase.erase_lo && o_erase.erase_hi); endproperty
   a_one_half: assert property (p_one_half) else $error("both halves erasing");
   property p_key; bad_key |=> !mass_on && !o_erase.erase_page; endproperty
   a_key: assert property (p_key) else $error("erase started without key");
   property p_hold; $rose(mass_on) |-> mass_on [*8]; endproperty
   a_hold: assert property (p_hold) else $error("mass erase ended early");
   property p_mass_max; mass_on |-> cnt_q <= MC + 1; endproperty
   a_mass_max: assert property (p_mass_max) else $error("mass erase never completes");
   c_lo: cover property ($rose(o_erase.erase_lo));
   c_hi: cover property ($rose(o_erase.erase_hi));
   c_page: cover property ($rose(o_erase.erase_page));
endmodule : fmep_top_asserts

bind fmep_top fmep_top_asserts #(.FLASH_KB(FLASH_KB), .MASS_ERASE_TIME_NS(MASS_ERASE_TIME_NS),
   .PAGE_ERASE_TIME_NS(PAGE_ERASE_TIME_NS)) u_fmep_top_asserts (.i_clk_sys, .i_rst_b, .i_wb, .o_wb_ack,
   .o_wb_dat, .o_irq, .o_erase);

// *** tb/fmep_top_test.sv ***
/*
 * Self-checking bench for the flash mass-erase block.
 * Assumes short erase times and a 128 KB array.
 */
`timescale 1ns/1ps
`include "fmep_cfg.svh"
module fmep_top_test;
   import fmep_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_rst_b = 1'b0;
   fmep_wb_req_t wb_q = '0;
   logic o_wb_ack;
   logic o_irq;
   logic [31:0] o_wb_dat;
   fmep_erase_t o_erase;
   int fails = 0;
   int checks = 0;
   int cyc_n = 0;
   logic [31:0] rd;
   logic [31:0] ris_m = 32'h0;
   logic [31:0] msk_m = 32'h0;
   logic [31:0] a;
   always #4 i_clk_sys = ~i_clk_sys;
   fmep_top #(.MASS_ERASE_TIME_NS(80), .PAGE_ERASE_TIME_NS(40)) u_fmep_top (.i_clk_sys, .i_rst_b,
      .i_wb(wb_q), .o_wb_ack, .o_wb_dat, .o_irq, .o_erase);
   // ****
   // tasks
   // ****
   task automatic final_report;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : final_report
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checks++;
      if (s !== e) begin
         fails++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic wb(input logic we, input logic [7:0] ad, input logic [31:0] d);
      @(posedge i_clk_sys);
      wb_q <= '{1'b1, 1'b1, we, ad, 4'hF, d};
      do @(posedge i_clk_sys); while (o_wb_ack !== 1'b1);
      rd = o_wb_dat;
      wb_q <= '0;
   endtask : wb
   task automatic rdchk(input logic [7:0] ad, input logic [31:0] e, input string n);
      wb(1'b0, ad, 32'h0);
      chk(n, e, rd);
   endtask : rdchk
   task automatic stat;
      rdchk(`FMEP_OFS_RIS, ris_m, "ris");
      chk("irq", {31'h0, |(ris_m & msk_m)}, {31'h0, o_irq});
   endtask : stat
   task automatic poll(input int b);
      for (int i = 0; i < 200; i++) begin
         wb(1'b0, `FMEP_OFS_CTRL, 32'h0);
         if (rd[b] === 1'b0) break;
      end
      chk("ctrl", 32'h0, rd);
   endtask : poll
   task automatic mass(input logic [31:0] ad, input logic ok);
      wb(1'b1, `FMEP_OFS_ADDR, ad);
      wb(1'b1, `FMEP_OFS_CTRL, 32'hA4420004);
      #1;
      chk("lo", {31'h0, ok & !ad[17]}, {31'h0, o_erase.erase_lo});
      chk("hi", {31'h0, ok & ad[17]}, {31'h0, o_erase.erase_hi});
      if (ok) begin
         chk("addr", {14'h0, ad[17:0]}, {14'h0, o_erase.page_addr});
         wb(1'b1, `FMEP_OFS_CTRL, 32'hA4420002);
         chk("busy page", 32'h0, {31'h0, o_erase.erase_page});
         rdchk(`FMEP_OFS_CTRL, 32'h4, "ctrl run");
         poll(2);
         ris_m[1] = 1'b1;
      end else ris_m[0] = 1'b1;
      stat;
   endtask : mass
   // ****
   // sequence
   // ****
   always @(posedge i_clk_sys) begin
      cyc_n++;
      if (cyc_n == 20000) begin
         fails++;
         final_report;
      end
   end
   initial begin
      a = $urandom(32'h797C3AD1);
      repeat (8) @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      for (int i = 0; i < 4; i++) rdchk(8'(`FMEP_OFS_PPW0 + 4 * i), i < 2 ? 32'hFFFFFFFF : 32'h0, "ppw");
      wb(1'b1, 8'h40, 32'hFFFFFFFF);
      rdchk(8'h40, 32'h0, "unmapped");
      msk_m = 32'h3;
      wb(1'b1, `FMEP_OFS_MASK, msk_m);
      mass({15'h0, a[16:0]}, 1'b1);
      ris_m = 32'h0;
      wb(1'b1, `FMEP_OFS_RIS, 32'h3);
      stat;
      wb(1'b1, `FMEP_OFS_CTRL, 32'h12340004);
      #1 chk("bad key", 32'h0, {31'h0, o_erase.erase_lo});
      rdchk(`FMEP_OFS_CTRL, 32'h0, "ctrl key");
      a = $urandom;
      mass({14'h0, 1'b1, a[16:0]}, 1'b1);
      wb(1'b1, `FMEP_OFS_RECOV, 32'h1);
      rdchk(8'(`FMEP_OFS_PPW0 + 8), 32'hFFFFFFFF, "ppw2");
      rdchk(8'(`FMEP_OFS_PPW0 + 12), 32'hFFFFFFFF, "ppw3");
      mass(32'h00020000, 1'b0);
      wb(1'b1, 8'(`FMEP_OFS_PPW0 + 8), 32'h0);
      wb(1'b1, 8'(`FMEP_OFS_PPW0 + 12), 32'h0);
      mass({14'h0, 1'b1, a[16:0]}, 1'b1);
      wb(1'b1, `FMEP_OFS_ADDR, {15'h0, a[16:0]});
      wb(1'b1, `FMEP_OFS_CTRL, 32'hA4420002);
      #1 chk("page", 32'h1, {31'h0, o_erase.erase_page});
      chk("page addr", {14'h0, 1'b0, a[16:10], 10'h0}, {14'h0, o_erase.page_addr});
      poll(1);
      ris_m[1] = 1'b1;
      stat;
      final_report;
   end
endmodule : fmep_top_test
